// ===== emon_ecu_model.sv
// Behavioural model of the engine control unit on the CAN side
`timescale 1ns/100ps
module emon_ecu_model #(
	parameter int PERIOD = 5
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Behaviour controls from the bench
	input  wire logic          talk,
	input  wire logic          alive,
	input  wire logic          boff,
	input  wire logic [15:0]   cond,
	// Link towards the monitor
	output emon_pkg::emon_ecu_t ecu
);
	import emon_pkg::*;

	logic [7:0] cnt_reg;
	logic       frame;

	// Frame pacing, one frame every PERIOD cycles while talking
	assign frame = talk && (cnt_reg == 8'(PERIOD - 1));
	always_ff @(posedge clk) begin
		if (!rst_n || !talk || frame)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_reg + 8'h01;
	end

	// Message pulses, held conditions and bus state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ecu <= '0;
		end else begin
			ecu.any_msg   <= frame;
			ecu.alive_msg <= frame && alive;
			ecu.cond      <= cond;
			ecu.bus_off   <= boff;
		end
	end
endmodule

// ===== emon_monitor.sv
// Engine anomaly monitor with APB register slave
`timescale 1ns/100ps

// Operation
// RULE_01: Pick-up failure enabled only when a tooth count or rpm/W ratio is set.
// RULE_02: Running with zero speed for the delay trips; zero delay disables.
// RULE_03: Pick-up failure severity comes from its own action field.
// RULE_04: Link loss and ECU anomalies need a nonzero engine type.
// RULE_05: Engine types 140 to 143 trip on missing alive message for its timeout.
// RULE_06: Other types trip on ECU silence for the silence time; zero disables.
// RULE_07: Link loss severity comes from the CAN-fault action field.
// RULE_08: Low-speed armed after fuel open and tolerance reached; off in start/stop.
// RULE_09: Armed low-speed trips when speed stays below threshold for the delay.
// RULE_10: ECU conditions raise anomalies at once unless masked.
// RULE_11: Mask bits 0 and 1 suppress low oil pressure pre-alarm and shutdown.
// RULE_12: Mask bits 2 and 3 suppress high oil temperature anomalies.
// RULE_13: Mask bits 4 and 5 suppress high coolant temperature anomalies.
// RULE_14: Mask bits 6 and 7 suppress low coolant level pre-alarm and shutdown.
// RULE_15: Mask bits 8 and 9 suppress water-in-fuel and low battery pre-alarms.
// RULE_16: Mask bits 10 and 11 suppress overspeed and charge alternator anomalies.
// RULE_17: Mask bits 14 and 15 suppress yellow lamp and red lamp anomalies.
// RULE_18: Mask bit 13 turns the red lamp shutdown into a pre-alarm.
// RULE_19: Configured analogue inputs above three thousand ohms raise a pre-alarm.
// RULE_20: Protections are evaluated only in manual and automatic modes.
// RULE_21: CAN bus-off raises a link failure with the CAN-fault severity.
// RULE_22: Persistence timers restart from zero when their condition drops.
module emon_monitor #(
	parameter int unsigned TICK_CYCLES = emon_pkg::EMON_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Engine state
	input  wire emon_pkg::emon_mode_t  op_mode,
	input  wire emon_pkg::emon_eng_t   eng,
	input  wire emon_pkg::emon_speed_t spd,
	// ECU link
	input  wire emon_pkg::emon_ecu_t   ecu,
	// Analogue sensors, ohms
	input  wire logic [15:0]        sensor_ohm [3],
	// Anomaly outputs
	output logic                    prealarm,
	output logic                    shutdown,
	output logic [31:0]             anomaly
);
	import emon_pkg::*;

	typedef enum logic {
		EMON_LS_DISARMED = 1'b0,
		EMON_LS_ARMED    = 1'b1
	} emon_ls_t;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Persistence counter step, restarting when the condition drops
	function automatic logic [15:0] emon_persist(input logic cond,
		input logic [15:0] cnt, input logic [15:0] dly, input logic tk);
		logic [15:0] r;
		r = cnt;
		if (!cond) begin
			r = 16'h0000;
		end else if (tk && cnt < dly) begin
			r = cnt + 16'h0001;
		end
		return r;
	endfunction

	// Expired when held for a nonzero delay
	function automatic logic emon_expired(input logic cond,
		input logic [15:0] cnt, input logic [15:0] dly);
		return cond && (dly != 16'h0000) && (cnt >= dly);
	endfunction

	// Action field to pre-alarm / shutdown pair
	function automatic logic [1:0] emon_sev(input logic [1:0] act);
		logic [1:0] r;
		case (emon_act_t'(act))
			EMON_ACT_PRE:   r = 2'b01;
			EMON_ACT_SHUT:  r = 2'b10;
			EMON_ACT_SHUT2: r = 2'b10;
			default:        r = 2'b00;
		endcase
		return r;
	endfunction

	// ****************************************************************
	// Registers and signals
	// ****************************************************************
	logic [31:0] speed_cfg_reg;
	logic [31:0] pickup_cfg_reg;
	logic [31:0] ecu_cfg_reg;
	logic [31:0] alive_cfg_reg;
	logic [31:0] lowspd_cfg_reg;
	logic [15:0] mask_reg;
	logic [2:0]  sensor_cfg_reg;
	logic [31:0] status_reg;
	logic [31:0] status_next;
	logic [31:0] prdata_reg;
	logic [21:0] tick_cnt_reg;
	logic        tick;
	logic [15:0] pickup_cnt_reg;
	logic [15:0] silence_cnt_reg;
	logic [15:0] lowspd_cnt_reg;
	emon_ls_t    ls_state_reg;
	logic        prealarm_reg;
	logic        shutdown_reg;

	logic        eval_en;
	logic        speed_meas;
	logic [15:0] sel_speed;
	logic        pickup_cond;
	logic        pickup_trip;
	logic [7:0]  eng_type;
	logic        can_en;
	logic        alive_type;
	logic        msg_seen;
	logic [15:0] silence_lim;
	logic        silence_cond;
	logic        comm_trip;
	logic        lowspd_cond;
	logic        lowspd_trip;
	logic [15:0] ecu_active;
	logic [2:0]  sensor_open;
	logic [31:0] pre_sel;
	logic [31:0] shut_sel;
	logic [1:0]  pick_sev;
	logic [1:0]  can_sev;
	logic        setup_ph;
	logic        wr_en;
	logic        addr_ok;
	logic        wr_status;

	// ****************************************************************
	// APB slave
	// ****************************************************************

	// Zero-wait slave, error on unmapped word
	always_comb begin
		case (paddr)
			EMON_SPEED_CFG_OFS, EMON_PICKUP_CFG_OFS, EMON_ECU_CFG_OFS,
			EMON_ALIVE_CFG_OFS, EMON_LOWSPD_CFG_OFS, EMON_MASK_OFS,
			EMON_SENSOR_CFG_OFS, EMON_STATUS_OFS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !addr_ok;
	assign setup_ph  = psel && !penable;
	assign wr_en     = psel && penable && pwrite && addr_ok;
	assign wr_status = wr_en && (paddr == EMON_STATUS_OFS);
	assign prdata    = prdata_reg;

	// Read data captured in the setup cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			case (paddr)
				EMON_SPEED_CFG_OFS:  prdata_reg <= speed_cfg_reg;
				EMON_PICKUP_CFG_OFS: prdata_reg <= pickup_cfg_reg;
				EMON_ECU_CFG_OFS:    prdata_reg <= ecu_cfg_reg;
				EMON_ALIVE_CFG_OFS:  prdata_reg <= alive_cfg_reg;
				EMON_LOWSPD_CFG_OFS: prdata_reg <= lowspd_cfg_reg;
				EMON_MASK_OFS:       prdata_reg <= {16'h0000, mask_reg};
				EMON_SENSOR_CFG_OFS: prdata_reg <= {29'h0, sensor_cfg_reg};
				EMON_STATUS_OFS:     prdata_reg <= status_reg;
				default:             prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration writes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			speed_cfg_reg  <= EMON_CFG_RST;
			pickup_cfg_reg <= EMON_CFG_RST;
			ecu_cfg_reg    <= EMON_CFG_RST;
			alive_cfg_reg  <= EMON_CFG_RST;
			lowspd_cfg_reg <= EMON_CFG_RST;
			mask_reg       <= EMON_MASK_RST;
			sensor_cfg_reg <= EMON_SENSOR_RST;
		end else if (wr_en) begin
			case (paddr)
				EMON_SPEED_CFG_OFS:  speed_cfg_reg  <= pwdata;
				EMON_PICKUP_CFG_OFS: pickup_cfg_reg <= pwdata;
				EMON_ECU_CFG_OFS:    ecu_cfg_reg    <= pwdata;
				EMON_ALIVE_CFG_OFS:  alive_cfg_reg  <= pwdata;
				EMON_LOWSPD_CFG_OFS: lowspd_cfg_reg <= pwdata;
				EMON_MASK_OFS:       mask_reg       <= pwdata[15:0];
				EMON_SENSOR_CFG_OFS: sensor_cfg_reg <= pwdata[2:0];
				default:             mask_reg       <= mask_reg;
			endcase
		end
	end

	// ****************************************************************
	// Tick divider
	// ****************************************************************

	// One-cycle pulse every tick period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_cnt_reg <= 22'h0;
		end else if (tick) begin
			tick_cnt_reg <= 22'h0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 22'h1;
		end
	end
	assign tick = (tick_cnt_reg == 22'(TICK_CYCLES - 1));

	// ****************************************************************
	// Protections
	// ****************************************************************

	// Only manual and automatic modes evaluate
	assign eval_en = (op_mode == EMON_MODE_MANUAL) ||
		(op_mode == EMON_MODE_AUTO); // RULE_20

	// Pick-up failure
	assign speed_meas  = (speed_cfg_reg[EMON_LO_LSB +: 16] != 16'h0) ||
		(speed_cfg_reg[EMON_HI_LSB +: 16] != 16'h0); // RULE_01
	assign sel_speed   = (speed_cfg_reg[EMON_LO_LSB +: 16] != 16'h0) ?
		spd.pickup_rpm : spd.w_rpm;
	assign pickup_cond = eval_en && speed_meas && eng.running &&
		(sel_speed == 16'h0); // RULE_02
	assign pickup_trip = emon_expired(pickup_cond, pickup_cnt_reg,
		pickup_cfg_reg[EMON_LO_LSB +: 16]); // RULE_02
	assign pick_sev    = emon_sev(pickup_cfg_reg[EMON_ACT_LSB +: 2]); // RULE_03

	// ECU link supervision
	assign eng_type    = ecu_cfg_reg[7:0];
	assign can_en      = eval_en && (eng_type != 8'h00); // RULE_04
	assign alive_type  = (eng_type >= EMON_ALIVE_TYPE_LO) &&
		(eng_type <= EMON_ALIVE_TYPE_HI);
	assign msg_seen    = alive_type ? ecu.alive_msg : ecu.any_msg; // RULE_05
	assign silence_lim = alive_type ? alive_cfg_reg[EMON_LO_LSB +: 16] :
		ecu_cfg_reg[EMON_HI_LSB +: 16]; // RULE_06
	assign silence_cond = can_en && !msg_seen;
	assign comm_trip   = emon_expired(silence_cond, silence_cnt_reg,
		silence_lim); // RULE_05 RULE_06
	assign can_sev     = emon_sev(ecu_cfg_reg[EMON_CACT_LSB +: 2]); // RULE_07

	// Low speed
	assign lowspd_cond = eval_en && (ls_state_reg == EMON_LS_ARMED) &&
		(spd.speed_rpm < lowspd_cfg_reg[EMON_LO_LSB +: 16]); // RULE_09
	assign lowspd_trip = emon_expired(lowspd_cond, lowspd_cnt_reg,
		lowspd_cfg_reg[EMON_HI_LSB +: 16]); // RULE_09

	// ECU conditions, masked per bit
	// RULE_11 RULE_12 RULE_13 RULE_14 RULE_15 RULE_16 RULE_17
	assign ecu_active = can_en ? (ecu.cond & ~mask_reg) : 16'h0000; // RULE_10

	// Open sensor lines
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			sensor_open[i] = eval_en && sensor_cfg_reg[i] &&
				(sensor_ohm[i] > EMON_OPEN_OHMS); // RULE_19
		end
	end

	// Persistence timers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pickup_cnt_reg  <= 16'h0;
			silence_cnt_reg <= 16'h0;
			lowspd_cnt_reg  <= 16'h0;
		end else begin
			pickup_cnt_reg  <= emon_persist(pickup_cond, pickup_cnt_reg,
				pickup_cfg_reg[EMON_LO_LSB +: 16], tick); // RULE_22
			silence_cnt_reg <= emon_persist(silence_cond, silence_cnt_reg,
				silence_lim, tick); // RULE_22
			lowspd_cnt_reg  <= emon_persist(lowspd_cond, lowspd_cnt_reg,
				lowspd_cfg_reg[EMON_HI_LSB +: 16], tick); // RULE_22
		end
	end

	// Low-speed arming
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ls_state_reg <= EMON_LS_DISARMED;
		end else begin
			case (ls_state_reg)
				EMON_LS_DISARMED: begin
					if (speed_meas && eng.fuel_open && !eng.start_stop &&
						eng.speed_in_tol && eng.volt_in_tol) begin
						ls_state_reg <= EMON_LS_ARMED; // RULE_08
					end
				end
				EMON_LS_ARMED: begin
					if (!speed_meas || !eng.fuel_open || eng.start_stop) begin
						ls_state_reg <= EMON_LS_DISARMED; // RULE_08
					end
				end
				default: ls_state_reg <= EMON_LS_DISARMED;
			endcase
		end
	end

	// ****************************************************************
	// Anomaly status and severity
	// ****************************************************************

	// Sticky flags, write one to clear, a new event wins
	always_comb begin
		status_next = status_reg;
		if (wr_status) begin
			status_next = status_reg & ~pwdata;
		end
		status_next[EMON_ST_PICKUP] = status_next[EMON_ST_PICKUP] |
			pickup_trip;
		status_next[EMON_ST_COMM] = status_next[EMON_ST_COMM] | comm_trip;
		status_next[EMON_ST_BUSOFF] = status_next[EMON_ST_BUSOFF] |
			(can_en && ecu.bus_off); // RULE_21
		status_next[EMON_ST_LOWSPD] = status_next[EMON_ST_LOWSPD] |
			lowspd_trip;
		status_next[EMON_ST_SENSOR +: 3] = status_next[EMON_ST_SENSOR +: 3] |
			sensor_open;
		status_next[EMON_ST_ECU +: 16] = status_next[EMON_ST_ECU +: 16] |
			(ecu_active & (EMON_ECU_PRE_BITS | EMON_ECU_SHUT_BITS));
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_reg <= EMON_STATUS_RST;
		end else begin
			status_reg <= status_next;
		end
	end

	// Severity selection per status bit
	always_comb begin
		pre_sel  = 32'h0000_0000;
		shut_sel = 32'h0000_0000;
		pre_sel[EMON_ST_PICKUP]  = pick_sev[0]; // RULE_03
		shut_sel[EMON_ST_PICKUP] = pick_sev[1]; // RULE_03
		pre_sel[EMON_ST_COMM]    = can_sev[0]; // RULE_07
		shut_sel[EMON_ST_COMM]   = can_sev[1]; // RULE_07
		pre_sel[EMON_ST_BUSOFF]  = can_sev[0]; // RULE_21
		shut_sel[EMON_ST_BUSOFF] = can_sev[1]; // RULE_21
		shut_sel[EMON_ST_LOWSPD] = 1'b1;
		pre_sel[EMON_ST_SENSOR +: 3] = 3'h7; // RULE_19
		pre_sel[EMON_ST_ECU +: 16]  = EMON_ECU_PRE_BITS;
		shut_sel[EMON_ST_ECU +: 16] = EMON_ECU_SHUT_BITS;
		if (mask_reg[EMON_MASK_RED_PRE]) begin
			pre_sel[EMON_ST_ECU + 15]  = 1'b1; // RULE_18
			shut_sel[EMON_ST_ECU + 15] = 1'b0; // RULE_18
		end
	end

	// Summary outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prealarm_reg <= 1'b0;
			shutdown_reg <= 1'b0;
		end else begin
			prealarm_reg <= |(status_reg & pre_sel);
			shutdown_reg <= |(status_reg & shut_sel);
		end
	end
	assign prealarm = prealarm_reg;
	assign shutdown = shutdown_reg;
	assign anomaly  = status_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_pickup_needs_meas: assert property (pickup_trip |-> speed_meas) // RULE_01
		else $error("pick-up failure without speed input");
	a_pickup_zero_off: assert property (
		(pickup_cfg_reg[15:0] == 16'h0) |-> !pickup_trip) // RULE_02
		else $error("pick-up failure with zero delay");
	a_timer_restart: assert property (!lowspd_cond |=> lowspd_cnt_reg == 16'h0) // RULE_22
		else $error("low-speed timer not restarted");
	a_can_type_gate: assert property (
		(eng_type == 8'h00) |-> (ecu_active == 16'h0 && !comm_trip)) // RULE_04
		else $error("ECU anomaly with no engine type");
	a_silence_zero_off: assert property (
		(!alive_type && ecu_cfg_reg[31:16] == 16'h0) |-> !comm_trip) // RULE_06
		else $error("silence check active with zero time");
	a_ecu_sets_flag: assert property (
		(ecu_active[1] && !mask_reg[1]) |=> status_reg[EMON_ST_ECU + 1]) // RULE_11
		else $error("low oil pressure shutdown not latched");
	a_lowspd_armed: assert property (
		lowspd_trip |-> ls_state_reg == EMON_LS_ARMED) // RULE_08
		else $error("low-speed trip while disarmed");
	a_mode_gate: assert property (
		(!eval_en && !wr_status) |=> $stable(status_reg)) // RULE_20
		else $error("status changed outside manual/auto");
	a_sensor_open: assert property (
		(eval_en && sensor_cfg_reg[0] && sensor_ohm[0] > EMON_OPEN_OHMS)
		|=> status_reg[EMON_ST_SENSOR]) // RULE_19
		else $error("open sensor not flagged");
	a_red_lamp_pre: assert property (
		(status_reg[31] && mask_reg[13] && status_reg[30:0] == 31'h0)
		|=> !shutdown) // RULE_18
		else $error("red lamp shut down while set to pre-alarm");

	c_pickup_trip: cover property (pickup_trip);
	c_comm_alive: cover property (comm_trip && alive_type);
	c_lowspd_trip: cover property (lowspd_trip);
	c_busoff: cover property (can_en && ecu.bus_off);

endmodule

// ===== emon_monitor_tb.sv
// Self-checking testbench of the engine anomaly monitor
`timescale 1ns/100ps
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module emon_monitor_tb;
	import emon_pkg::*;
	localparam int          TK    = 10;
	localparam logic [15:0] PRE_M = 16'h4b55;
	localparam logic [15:0] SHT_M = 16'h84aa;
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	emon_mode_t  op_mode;
	emon_eng_t   eng;
	emon_speed_t spd;
	emon_ecu_t   ecu;
	logic [15:0] sensor_ohm [3];
	logic        prealarm;
	logic        shutdown;
	logic [31:0] anomaly;
	logic        talk;
	logic        alive;
	logic        boff;
	logic [15:0] cond;
	logic [31:0] rd_data;
	logic [31:0] eb;
	logic        rd_err;
	int          err_count;
	int          checks_done;
	int          cyc;

	// Design and ECU model
	emon_monitor #(.TICK_CYCLES(TK)) u_dut (
		.clk        (clk),
		.rst_n      (rst_n),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.op_mode    (op_mode),
		.eng        (eng),
		.spd        (spd),
		.ecu        (ecu),
		.sensor_ohm (sensor_ohm),
		.prealarm   (prealarm),
		.shutdown   (shutdown),
		.anomaly    (anomaly)
	);
	emon_ecu_model #(.PERIOD(5)) u_ecu (
		.clk   (clk),
		.rst_n (rst_n),
		.talk  (talk),
		.alive (alive),
		.boff  (boff),
		.cond  (cond),
		.ecu   (ecu)
	);

	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_data = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd_data, e)
	endtask

	// Reset with all inputs idle
	task automatic reset_all();
		rst_n      <= 1'b0;
		psel       <= 1'b0;
		penable    <= 1'b0;
		pwrite     <= 1'b0;
		paddr      <= 8'h00;
		pwdata     <= 32'h0;
		op_mode    <= EMON_MODE_AUTO;
		eng        <= '0;
		spd        <= '0;
		sensor_ohm <= '{default: 16'h0};
		talk       <= 1'b0;
		alive      <= 1'b0;
		boff       <= 1'b0;
		cond       <= 16'h0;
		tk(2);
		rst_n <= 1'b1;
		tk(1);
	endtask

	initial begin
		reset_all();
		rchk(EMON_MASK_OFS, 32'h0);
		wr(EMON_MASK_OFS, 32'hffff_ffff);
		rchk(EMON_MASK_OFS, 32'h0000_ffff);
		apb(1'b0, 8'h20, 32'h0);
		`CHK({rd_err, rd_data}, 33'h1_0000_0000)
		$display("test registers done");
		// ECU conditions: type gate, mode gate, mask and severity
		wr(EMON_MASK_OFS, 32'h0);
		cond <= 16'hffff;
		tk(6);
		rchk(EMON_STATUS_OFS, 32'h0);
		op_mode <= EMON_MODE_TEST;
		wr(EMON_ECU_CFG_OFS, 32'h1);
		tk(4);
		rchk(EMON_STATUS_OFS, 32'h0);
		cond    <= 16'h0;
		tk(2);
		op_mode <= EMON_MODE_MANUAL;
		for (int i = 0; i < 16; i++) begin
			if (i == 12 || i == 13)
				continue;
			eb = 32'h1 << (16 + i);
			wr(EMON_MASK_OFS, 32'h1 << i);
			cond <= 16'h1 << i;
			tk(4);
			rchk(EMON_STATUS_OFS, 32'h0);
			wr(EMON_MASK_OFS, 32'h0);
			tk(3);
			rchk(EMON_STATUS_OFS, eb);
			`CHK({prealarm, shutdown}, {PRE_M[i], SHT_M[i]})
			cond <= 16'h0;
			wr(EMON_STATUS_OFS, eb);
			tk(3);
			rchk(EMON_STATUS_OFS, 32'h0);
		end
		wr(EMON_MASK_OFS, 32'h2000);
		cond <= 16'h8000;
		tk(4);
		`CHK({prealarm, shutdown}, 2'b10)
		$display("test ecu conditions done");
		// Pick-up failure: measure gate, restart, severity
		reset_all();
		eng.running <= 1'b1;
		wr(EMON_PICKUP_CFG_OFS, 32'h0002_0003);
		tk(50);
		rchk(EMON_STATUS_OFS, 32'h0);
		wr(EMON_SPEED_CFG_OFS, 32'h5);
		tk(15);
		rchk(EMON_STATUS_OFS, 32'h0);
		eng.running <= 1'b0;
		tk(2);
		eng.running <= 1'b1;
		tk(14);
		rchk(EMON_STATUS_OFS, 32'h0);
		tk(40);
		rchk(EMON_STATUS_OFS, 32'h1);
		`CHK({prealarm, shutdown}, 2'b01)
		$display("test pickup done");
		// Link silence and bus-off with CAN-fault severity
		reset_all();
		wr(EMON_ECU_CFG_OFS, 32'h0003_0101);
		talk <= 1'b1;
		tk(60);
		rchk(EMON_STATUS_OFS, 32'h0);
		talk <= 1'b0;
		tk(45);
		rchk(EMON_STATUS_OFS, 32'h2);
		`CHK({prealarm, shutdown}, 2'b10)
		boff <= 1'b1;
		wr(EMON_ECU_CFG_OFS, 32'h0003_0201);
		tk(4);
		rchk(EMON_STATUS_OFS, 32'h6);
		`CHK({prealarm, shutdown}, 2'b01)
		$display("test link done");
		// Alive message timeout for the first and last special types
		for (int t = 0; t < 2; t++) begin
			reset_all();
			wr(EMON_ALIVE_CFG_OFS, 32'h3);
			wr(EMON_ECU_CFG_OFS, t ? 32'h18f : 32'h18c);
			talk  <= 1'b1;
			alive <= 1'b1;
			tk(60);
			rchk(EMON_STATUS_OFS, 32'h0);
			alive <= 1'b0;
			tk(45);
			rchk(EMON_STATUS_OFS, 32'h2);
		end
		$display("test alive done");
		// Low speed: arming, then trip just below threshold
		reset_all();
		wr(EMON_SPEED_CFG_OFS, 32'h5);
		wr(EMON_LOWSPD_CFG_OFS, 32'h0002_0064);
		spd.speed_rpm <= 16'h0063;
		spd.pickup_rpm <= 16'h0063;
		eng <= 5'b10011;
		tk(40);
		rchk(EMON_STATUS_OFS, 32'h0);
		eng <= 5'b11011;
		tk(40);
		rchk(EMON_STATUS_OFS, 32'h8);
		`CHK(shutdown, 1'b1)
		$display("test low speed done");
		// Open sensor: limit is exclusive, unconfigured input ignored
		reset_all();
		wr(EMON_SENSOR_CFG_OFS, 32'h5);
		sensor_ohm <= '{3{16'h0bb8}};
		tk(4);
		rchk(EMON_STATUS_OFS, 32'h0);
		sensor_ohm <= '{3{16'h0bb9}};
		tk(4);
		rchk(EMON_STATUS_OFS, 32'h50);
		`CHK(prealarm, 1'b1)
		`CHK(anomaly, 32'h0000_0050)
		$display("test sensors done");
		give_verdict();
	end
endmodule

// ===== emon_pkg.sv
// Package of constants, types and the register map of the anomaly monitor
package emon_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned EMON_CLK_PERIOD_NS = 40;
	localparam int unsigned EMON_TICK_PERIOD_MS = 100;
	localparam int unsigned EMON_TICK_CYCLES =
		EMON_TICK_PERIOD_MS * 1000000 / EMON_CLK_PERIOD_NS;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] EMON_SPEED_CFG_OFS  = 8'h00;
	localparam logic [7:0] EMON_PICKUP_CFG_OFS = 8'h04;
	localparam logic [7:0] EMON_ECU_CFG_OFS    = 8'h08;
	localparam logic [7:0] EMON_ALIVE_CFG_OFS  = 8'h0c;
	localparam logic [7:0] EMON_LOWSPD_CFG_OFS = 8'h10;
	localparam logic [7:0] EMON_MASK_OFS       = 8'h14;
	localparam logic [7:0] EMON_SENSOR_CFG_OFS = 8'h18;
	localparam logic [7:0] EMON_STATUS_OFS     = 8'h1c;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int EMON_LO_LSB   = 0;
	localparam int EMON_HI_LSB   = 16;
	localparam int EMON_ACT_LSB  = 16;
	localparam int EMON_CACT_LSB = 8;
	localparam int EMON_ST_PICKUP = 0;
	localparam int EMON_ST_COMM   = 1;
	localparam int EMON_ST_BUSOFF = 2;
	localparam int EMON_ST_LOWSPD = 3;
	localparam int EMON_ST_SENSOR = 4;
	localparam int EMON_ST_ECU    = 16;
	localparam int EMON_MASK_RED_PRE = 13;

	// ****************************************************************
	// Reset values and fixed figures
	// ****************************************************************
	localparam logic [31:0] EMON_CFG_RST    = 32'h0000_0000;
	localparam logic [15:0] EMON_MASK_RST   = 16'h0000;
	localparam logic [2:0]  EMON_SENSOR_RST = 3'h0;
	localparam logic [31:0] EMON_STATUS_RST = 32'h0000_0000;
	localparam logic [7:0]  EMON_ALIVE_TYPE_LO = 8'h8c;
	localparam logic [7:0]  EMON_ALIVE_TYPE_HI = 8'h8f;
	localparam logic [15:0] EMON_OPEN_OHMS     = 16'h0bb8;
	localparam logic [15:0] EMON_ECU_PRE_BITS  = 16'h4b55;
	localparam logic [15:0] EMON_ECU_SHUT_BITS = 16'h84aa;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		EMON_ACT_NONE  = 2'b00,
		EMON_ACT_PRE   = 2'b01,
		EMON_ACT_SHUT  = 2'b10,
		EMON_ACT_SHUT2 = 2'b11
	} emon_act_t;

	typedef enum logic [1:0] {
		EMON_MODE_OFF    = 2'b00,
		EMON_MODE_MANUAL = 2'b01,
		EMON_MODE_AUTO   = 2'b10,
		EMON_MODE_TEST   = 2'b11
	} emon_mode_t;

	typedef struct packed {
		logic running;
		logic fuel_open;
		logic start_stop;
		logic speed_in_tol;
		logic volt_in_tol;
	} emon_eng_t;

	typedef struct packed {
		logic        bus_off;
		logic        any_msg;
		logic        alive_msg;
		logic [15:0] cond;
	} emon_ecu_t;

	typedef struct packed {
		logic [15:0] pickup_rpm;
		logic [15:0] w_rpm;
		logic [15:0] speed_rpm;
	} emon_speed_t;

endpackage
